// ===== inc/trr_pkg.sv
// Constants, field layouts and register map of the trigger router
//
// Overview of operation
// - Software can drive any mux input or output line through the command register.
// - Command group field picks the trigger group holding the driven line.
// - Command direction field picks mux output or mux input within that group.
// - Command line field picks the exact line inside the chosen group.
// - Command count field sets how many clock cycles the line is held active.
// - Software sets activate; hardware clears it once the count has run out.
// - Driving a distribution output reaches only the destination it feeds.
// - Driving a reduction input reaches every destination routed from it.
// - Each distribution group has its own clock for manipulation and pulses.
// - Fifteen groups: 0 to 8 distribution, 9 to 14 reduction.
// - USB burst-end and logic acknowledge routes need only one mux.
// - One output control register per mux output: select, invert, edge.
// - Distribution groups feed DMA0, DMA1, timers, profiler, CPU, analog, logic, IO.
// - Group 9 routes DMA triggers to burst-end lines, with manipulation.
// - Group 10 gathers DMA triggers into intermediates, with manipulation.
// - Groups 11 to 14 gather other triggers, without any manipulation.
// - Edge mode syncs to consumer clock in groups 0 to 8, to system clock in 9 and 10, and emits a two-cycle pulse.
package trr_pkg;

  localparam int NGRP      = 15;
  localparam int NDIST     = 9;
  localparam int FIRST_RED = 9;
  localparam int MANIP_MAX = 10;
  localparam int NOUT      = 4;
  localparam int NRIN      = 8;
  localparam int NINT      = 20;
  localparam int NIN       = 20;
  localparam int SYNC_LEN  = 3;
  localparam int PULSE_LEN = 2;

  // Register map
  localparam logic [15:0] CMD_ADDR    = 16'h0000;
  localparam logic [3:0]  CTL_PAGE    = 4'h1;
  localparam int          CTL_GRP_LSB = 6;
  localparam int          CTL_LIN_LSB = 2;

  // Command fields
  localparam int CMD_LINE_LSB = 0;
  localparam int CMD_GRP_LSB  = 8;
  localparam int CMD_CNT_LSB  = 16;
  localparam int CMD_DIR_BIT  = 29;
  localparam int CMD_ACT_BIT  = 31;

  // Output control fields
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_INV_BIT = 8;
  localparam int CTL_EDG_BIT = 9;

  localparam logic [7:0]  SEL_RST  = 8'h00;
  localparam logic [7:0]  CNT_RST  = 8'h00;
  localparam logic [31:0] RD_IDLE  = 32'h0000_0000;
  localparam logic [1:0]  PULSE_CNT = 2'h2;

endpackage : trr_pkg

// ===== rtl/trr_line_manip.sv
// Per-line inversion, edge or level treatment and software drive
`timescale 1ns/1ps
module trr_line_manip
  import trr_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic trig_in,
  input  wire logic invert,
  input  wire logic edge_mode,
  input  wire logic sw_drive,
  output logic      trig_out
);

  logic       prev_q;
  logic       prev_d;
  logic [1:0] pulse_q;
  logic [1:0] pulse_d;
  logic       out_d;
  logic       lvl;

  always_comb begin
    lvl     = trig_in ^ invert;
    prev_d  = prev_q;
    pulse_d = pulse_q;
    if (tick) begin
      prev_d = lvl;
      if (pulse_q != 2'h0) begin
        pulse_d = pulse_q - 2'h1;
      end
      if (lvl && !prev_q) begin
        pulse_d = PULSE_CNT;
      end
    end
    out_d = (edge_mode ? (pulse_q != 2'h0) : lvl) | sw_drive;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q   <= 1'b0;
      pulse_q  <= 2'h0;
      trig_out <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      pulse_q  <= pulse_d;
      trig_out <= out_d;
    end
  end

endmodule : trr_line_manip

// ===== rtl/trr_router.sv
// Two-layer trigger router with software trigger command
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module trr_router
  import trr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire logic [NDIST-1:0]      group_clk,
  input  wire logic [NRIN-1:0]       dma_trig,
  input  wire logic [NRIN-1:0]       timer_trig,
  input  wire logic [NRIN-1:0]       io_trig,
  input  wire logic [NRIN-1:0]       serial_trig,
  input  wire logic [NRIN-1:0]       misc_trig,
  output logic [NDIST*NOUT-1:0]      dest_trig,
  output logic [1:0]                 usb_burst_end,
  output logic [1:0]                 pl_ack,
  output logic                       sw_busy
);

  // Output control registers, one per mux output
  logic [7:0] sel_q  [NGRP][NOUT];
  logic [7:0] sel_d  [NGRP][NOUT];
  logic       inv_q  [NGRP][NOUT];
  logic       inv_d  [NGRP][NOUT];
  logic       edg_q  [NGRP][NOUT];
  logic       edg_d  [NGRP][NOUT];

  // Command register state
  logic [7:0] cmd_line_q;
  logic [7:0] cmd_line_d;
  logic [4:0] cmd_grp_q;
  logic [4:0] cmd_grp_d;
  logic [7:0] cmd_cnt_q;
  logic [7:0] cmd_cnt_d;
  logic       cmd_dir_q;
  logic       cmd_dir_d;
  logic       act_q;
  logic       act_d;
  logic [7:0] remain_q;
  logic [7:0] remain_d;
  logic       drive;

  // Bus
  logic        cmd_hit;
  logic        ctl_hit;
  logic [3:0]  ctl_grp;
  logic [3:0]  ctl_lin;
  logic [31:0] rdata_d;

  // Group clock synchronisers
  logic [SYNC_LEN-1:0] gsync_q [NDIST];
  logic [SYNC_LEN-1:0] gsync_d [NDIST];
  logic [NDIST-1:0]    glvl_q;
  logic [NDIST-1:0]    glvl_d;
  logic [NDIST-1:0]    tick;

  // Routing
  logic [NIN-1:0]  src_vec  [NGRP];
  logic [NIN-1:0]  sw_in    [NGRP];
  logic [NIN-1:0]  mux_in   [NGRP];
  logic [NOUT-1:0] sw_out   [NGRP];
  logic [NOUT-1:0] mux_out  [NGRP];
  logic [NOUT-1:0] line_out [NGRP];
  logic [NINT-1:0] inter;

  // Address decode
  always_comb begin
    cmd_hit = (reg_addr == CMD_ADDR);
    ctl_grp = reg_addr[CTL_GRP_LSB +: 4];
    ctl_lin = reg_addr[CTL_LIN_LSB +: 4];
    ctl_hit = (reg_addr[15:12] == CTL_PAGE) && (reg_addr[11:10] == 2'b00) && (reg_addr[1:0] == 2'b00)
              && (int'(ctl_grp) < NGRP) && (int'(ctl_lin) < NOUT);
  end

  // Output control registers
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      for (int l = 0; l < NOUT; l++) begin
        sel_d[g][l] = sel_q[g][l];
        inv_d[g][l] = inv_q[g][l];
        edg_d[g][l] = edg_q[g][l];
        if (reg_wr && ctl_hit && int'(ctl_grp) == g && int'(ctl_lin) == l) begin
          sel_d[g][l] = reg_wdata[CTL_SEL_LSB +: 8];
          inv_d[g][l] = (g <= MANIP_MAX) ? reg_wdata[CTL_INV_BIT] : 1'b0;
          edg_d[g][l] = (g <= MANIP_MAX) ? reg_wdata[CTL_EDG_BIT] : 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int g = 0; g < NGRP; g++) begin
        for (int l = 0; l < NOUT; l++) begin
          sel_q[g][l] <= SEL_RST;
          inv_q[g][l] <= 1'b0;
          edg_q[g][l] <= 1'b0;
        end
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        for (int l = 0; l < NOUT; l++) begin
          sel_q[g][l] <= sel_d[g][l];
          inv_q[g][l] <= inv_d[g][l];
          edg_q[g][l] <= edg_d[g][l];
        end
      end
    end
  end

  // Software trigger command
  always_comb begin
    cmd_line_d = cmd_line_q;
    cmd_grp_d  = cmd_grp_q;
    cmd_cnt_d  = cmd_cnt_q;
    cmd_dir_d  = cmd_dir_q;
    act_d      = act_q;
    remain_d   = remain_q;
    if (act_q) begin
      if (remain_q == 8'h00) begin
        act_d = 1'b0;
      end else begin
        remain_d = remain_q - 8'h01;
      end
    end else if (reg_wr && cmd_hit) begin
      cmd_line_d = reg_wdata[CMD_LINE_LSB +: 8];
      cmd_grp_d  = reg_wdata[CMD_GRP_LSB +: 5];
      cmd_cnt_d  = reg_wdata[CMD_CNT_LSB +: 8];
      cmd_dir_d  = reg_wdata[CMD_DIR_BIT];
      act_d      = reg_wdata[CMD_ACT_BIT];
      remain_d   = reg_wdata[CMD_CNT_LSB +: 8];
    end
    drive = act_q && (remain_q != 8'h00);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_line_q <= 8'h00;
      cmd_grp_q  <= 5'h00;
      cmd_cnt_q  <= CNT_RST;
      cmd_dir_q  <= 1'b0;
      act_q      <= 1'b0;
      remain_q   <= CNT_RST;
      sw_busy    <= 1'b0;
    end else begin
      cmd_line_q <= cmd_line_d;
      cmd_grp_q  <= cmd_grp_d;
      cmd_cnt_q  <= cmd_cnt_d;
      cmd_dir_q  <= cmd_dir_d;
      act_q      <= act_d;
      remain_q   <= remain_d;
      sw_busy    <= act_d;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = RD_IDLE;
    if (reg_rd && cmd_hit) begin
      rdata_d[CMD_LINE_LSB +: 8] = cmd_line_q;
      rdata_d[CMD_GRP_LSB +: 5]  = cmd_grp_q;
      rdata_d[CMD_CNT_LSB +: 8]  = cmd_cnt_q;
      rdata_d[CMD_DIR_BIT]       = cmd_dir_q;
      rdata_d[CMD_ACT_BIT]       = act_q;
    end else if (reg_rd && ctl_hit) begin
      for (int g = 0; g < NGRP; g++) begin
        for (int l = 0; l < NOUT; l++) begin
          if (int'(ctl_grp) == g && int'(ctl_lin) == l) begin
            rdata_d[CTL_SEL_LSB +: 8] = sel_q[g][l];
            rdata_d[CTL_INV_BIT]      = inv_q[g][l];
            rdata_d[CTL_EDG_BIT]      = edg_q[g][l];
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= RD_IDLE;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Distribution group clocks: three flops, rising edge once two agree
  always_comb begin
    for (int g = 0; g < NDIST; g++) begin
      gsync_d[g] = {gsync_q[g][SYNC_LEN-2:0], group_clk[g]};
      glvl_d[g]  = glvl_q[g];
      if (gsync_q[g][1] == gsync_q[g][2]) begin
        glvl_d[g] = gsync_q[g][2];
      end
      tick[g] = gsync_q[g][1] && gsync_q[g][2] && !glvl_q[g];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int g = 0; g < NDIST; g++) begin
        gsync_q[g] <= '0;
      end
      glvl_q <= '0;
    end else begin
      for (int g = 0; g < NDIST; g++) begin
        gsync_q[g] <= gsync_d[g];
      end
      glvl_q <= glvl_d;
    end
  end

  // Mux sources and software injection per group
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      if (g < NDIST) begin
        src_vec[g] = inter;
      end else if (g <= MANIP_MAX) begin
        src_vec[g] = {{(NIN-NRIN){1'b0}}, dma_trig};
      end else if (g == 11) begin
        src_vec[g] = {{(NIN-NRIN){1'b0}}, timer_trig};
      end else if (g == 12) begin
        src_vec[g] = {{(NIN-NRIN){1'b0}}, io_trig};
      end else if (g == 13) begin
        src_vec[g] = {{(NIN-NRIN){1'b0}}, serial_trig};
      end else begin
        src_vec[g] = {{(NIN-NRIN){1'b0}}, misc_trig};
      end
      for (int i = 0; i < NIN; i++) begin
        sw_in[g][i] = drive && !cmd_dir_q && int'(cmd_grp_q) == g && int'(cmd_line_q) == i;
      end
      for (int l = 0; l < NOUT; l++) begin
        sw_out[g][l] = drive && cmd_dir_q && int'(cmd_grp_q) == g && int'(cmd_line_q) == l;
      end
      mux_in[g] = src_vec[g] | sw_in[g];
      for (int l = 0; l < NOUT; l++) begin
        mux_out[g][l] = (int'(sel_q[g][l]) < NIN) ? mux_in[g][sel_q[g][l][4:0]] : 1'b0;
      end
    end
  end

  // Per-group output stage
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    for (genvar l = 0; l < NOUT; l++) begin : g_line
      if (g <= MANIP_MAX) begin : g_manip
        trr_line_manip u_manip (
          .clock     (clock),
          .rst       (rst),
          .tick      ((g < NDIST) ? tick[g % NDIST] : 1'b1),
          .trig_in   (mux_out[g][l]),
          .invert    (inv_q[g][l]),
          .edge_mode (edg_q[g][l]),
          .sw_drive  (sw_out[g][l]),
          .trig_out  (line_out[g][l])
        );
      end else begin : g_plain
        assign line_out[g][l] = mux_out[g][l] | sw_out[g][l];
      end
    end
  end

  // Intermediate bus from groups 10 to 14
  always_comb begin
    for (int g = MANIP_MAX; g < NGRP; g++) begin
      inter[(g-MANIP_MAX)*NOUT +: NOUT] = line_out[g];
    end
  end

  // Destinations, all from flops in the manipulation stage
  always_comb begin
    for (int g = 0; g < NDIST; g++) begin
      dest_trig[g*NOUT +: NOUT] = line_out[g];
    end
    usb_burst_end = line_out[FIRST_RED][1:0];
    pl_ack        = line_out[FIRST_RED][3:2];
  end

endmodule : trr_router

// ===== bench/trr_assertions.sv
// Port checks of the trigger router and their bind
`timescale 1ns/1ps
module trr_assertions
  import trr_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic [15:0]           reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic [NDIST*NOUT-1:0] dest_trig,
  input wire logic [1:0]            usb_burst_end,
  input wire logic [1:0]            pl_ack,
  input wire logic                  sw_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic       acc;
  logic       out_w;
  logic [4:0] grp_w;
  logic [7:0] lin_w;
  logic [7:0] exp_q;
  logic [8:0] run_q;
  assign acc   = reg_wr && reg_addr == CMD_ADDR && reg_wdata[CMD_ACT_BIT] && !sw_busy;
  assign out_w = acc && reg_wdata[CMD_DIR_BIT] && reg_wdata[CMD_CNT_LSB+:8] != 8'h00;
  assign grp_w = reg_wdata[CMD_GRP_LSB+:5];
  assign lin_w = reg_wdata[CMD_LINE_LSB+:8];
  // Accepted count and busy length
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exp_q <= 8'h00;
      run_q <= 9'h000;
    end else begin
      if (acc) exp_q <= reg_wdata[CMD_CNT_LSB+:8];
      run_q <= sw_busy ? run_q + 9'h001 : 9'h000;
    end
  end
  property p_busy_start; acc |=> sw_busy; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised by command");
  property p_busy_rise; $rose(sw_busy) |-> $past(acc); endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy raised without command");
  property p_busy_len; $fell(sw_busy) |-> run_q == {1'b0, exp_q} + 9'h001; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length differs from count");
  property p_act_read; reg_rd && reg_addr == CMD_ADDR |=> reg_rdata[CMD_ACT_BIT] == $past(sw_busy); endproperty
  a_act_read: assert property (p_act_read) else $error("activate bit reads wrong");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == RD_IDLE; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read answer");
  property p_out_drive;
    int i;
    (out_w && grp_w < 5'(NDIST) && lin_w < 8'(NOUT), i = grp_w * NOUT + lin_w) |-> ##2 dest_trig[i];
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("driven output line low");
  property p_usb; int i; (out_w && grp_w == 5'd9 && lin_w < 8'd2, i = lin_w) |-> ##2 usb_burst_end[i]; endproperty
  a_usb: assert property (p_usb) else $error("burst end line not driven");
  property p_ack;
    int i;
    (out_w && grp_w == 5'd9 && lin_w inside {8'd2, 8'd3}, i = lin_w - 2) |-> ##2 pl_ack[i];
  endproperty
  a_ack: assert property (p_ack) else $error("logic acknowledge line not driven");
  c_acc: cover property (acc);
  c_refused: cover property (reg_wr && reg_addr == CMD_ADDR && sw_busy);
  c_done: cover property ($fell(sw_busy));
endmodule : trr_assertions

bind trr_router trr_assertions i_trr_assertions (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dest_trig(dest_trig),
  .usb_burst_end(usb_burst_end), .pl_ack(pl_ack), .sw_busy(sw_busy));

// ===== bench/trr_periph_model.sv
// Source peripherals and consumer clocks around the router
`timescale 1ns/1ps
module trr_periph_model
  import trr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  output logic [NDIST-1:0] group_clk,
  output logic [NRIN-1:0]  dma_trig,
  output logic [NRIN-1:0]  timer_trig,
  output logic [NRIN-1:0]  io_trig,
  output logic [NRIN-1:0]  serial_trig,
  output logic [NRIN-1:0]  misc_trig
);
  logic [NRIN-1:0] dma_q = 8'h00;
  logic [7:0]      cnt_q;
  // Own free running clock per consumer group
  for (genvar g = 0; g < NDIST; g++) begin : g_clk
    initial begin
      group_clk[g] = 1'b0;
      forever #(12 + 2 * g) group_clk[g] = ~group_clk[g];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign dma_trig    = dma_q;
  assign timer_trig  = cnt_q;
  assign io_trig     = ~cnt_q;
  assign serial_trig = {cnt_q[3:0], cnt_q[7:4]};
  assign misc_trig   = cnt_q ^ 8'h5a;
  task automatic set_dma(input int b, input logic v);
    dma_q[b] <= v;
  endtask : set_dma
endmodule : trr_periph_model

// ===== bench/tb.sv
// Self-checking bench of the trigger router
`timescale 1ns/1ps
module tb;
  import trr_pkg::*;
  logic                  clock;
  logic                  rst;
  logic [15:0]           reg_addr;
  logic [31:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_rdata;
  logic [NDIST-1:0]      group_clk;
  logic [NRIN-1:0]       dma_trig;
  logic [NRIN-1:0]       timer_trig;
  logic [NRIN-1:0]       io_trig;
  logic [NRIN-1:0]       serial_trig;
  logic [NRIN-1:0]       misc_trig;
  logic [NDIST*NOUT-1:0] dest_trig;
  logic [1:0]            usb_burst_end;
  logic [1:0]            pl_ack;
  logic                  sw_busy;
  logic [39:0]           all_out;
  logic [31:0]           got;
  int                    n_mismatch;
  int                    checks_done;
  assign all_out = {pl_ack, usb_burst_end, dest_trig};
  trr_router i_trr_router (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .group_clk(group_clk), .dma_trig(dma_trig),
    .timer_trig(timer_trig), .io_trig(io_trig), .serial_trig(serial_trig), .misc_trig(misc_trig),
    .dest_trig(dest_trig), .usb_burst_end(usb_burst_end), .pl_ack(pl_ack), .sw_busy(sw_busy));
  trr_periph_model u_model (.clock(clock), .rst(rst), .group_clk(group_clk), .dma_trig(dma_trig),
    .timer_trig(timer_trig), .io_trig(io_trig), .serial_trig(serial_trig), .misc_trig(misc_trig));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] cmdw(input logic dir, input int g, input logic [7:0] n, input int l);
    return (32'h8000_0000 | (32'(dir) << CMD_DIR_BIT) | (32'(g) << CMD_GRP_LSB) | (32'(n) << CMD_CNT_LSB) | 32'(l));
  endfunction : cmdw
  function automatic logic [15:0] ca(input int g, input int l);
    return {CTL_PAGE, 12'h000} + 16'(g << CTL_GRP_LSB) + 16'(l << CTL_LIN_LSB);
  endfunction : ca
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask : bus
  task automatic rd(input logic [15:0] a);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
    #1;
  endtask : idle
  task automatic t_reset();
    rd(CMD_ADDR);
    check("command reset", got, 32'h0000_0000);
    rd(ca(0, 0));
    check("control reset", got, 32'h0000_0000);
    rd(16'h0800);
    check("unmapped read", got, 32'h0000_0000);
  endtask : t_reset
  task automatic t_sw_out(input int g, input int l);
    int hits;
    int others;
    int idx;
    hits = 0;
    others = 0;
    idx = (g < NDIST) ? g * NOUT + l : 36 + l;
    bus(1'b1, 1'b0, CMD_ADDR, cmdw(1'b1, g, 8'h03, l));
    bus(1'b1, 1'b0, CMD_ADDR, cmdw(1'b1, 1, 8'h05, 0));
    #1;
    repeat (8) begin
      hits += (all_out[idx] === 1'b1);
      others += ((all_out & ~(40'h00_0000_0001 << idx)) !== 40'h00_0000_0000);
      idle(1);
    end
    check("driven cycles", hits, 3);
    check("other lines", others, 0);
    rd(CMD_ADDR);
    check("activate cleared", got[CMD_ACT_BIT], 1'b0);
  endtask : t_sw_out
  task automatic t_sw_in();
    int full;
    full = 0;
    bus(1'b1, 1'b0, CMD_ADDR, cmdw(1'b0, 10, 8'h02, 0));
    repeat (10) begin
      idle(1);
      full += (dest_trig === '1);
    end
    check("fan out cycles", full, 2);
  endtask : t_sw_in
  task automatic t_sw_dist();
    int hits;
    int stray;
    hits = 0;
    stray = 0;
    bus(1'b1, 1'b0, CMD_ADDR, cmdw(1'b0, 4, 8'h02, 0));
    #1;
    repeat (6) begin
      hits += (dest_trig[19:16] === 4'hf);
      stray += ((dest_trig & ~36'h0_000f_0000) !== 36'h0_0000_0000);
      idle(1);
    end
    check("input drive cycles", hits, 2);
    check("input drive spread", stray, 0);
    bus(1'b1, 1'b0, CMD_ADDR, cmdw(1'b1, 0, 8'h00, 0));
    #1;
    repeat (4) begin
      stray += (dest_trig[0] !== 1'b0);
      idle(1);
    end
    rd(CMD_ADDR);
    check("zero count drive", stray, 0);
    check("zero count clears", got[CMD_ACT_BIT], 1'b0);
  endtask : t_sw_dist
  task automatic t_route();
    bus(1'b1, 1'b0, ca(10, 1), 32'h0000_0003);
    bus(1'b1, 1'b0, ca(2, 0), 32'h0000_0001);
    u_model.set_dma(3, 1'b1);
    idle(6);
    check("routed line", dest_trig[8], 1'b1);
    check("unrouted line", dest_trig[0], 1'b0);
    u_model.set_dma(3, 1'b0);
  endtask : t_route
  task automatic t_manip();
    bus(1'b1, 1'b0, ca(9, 0), 32'h0000_0100);
    bus(1'b1, 1'b0, ca(12, 0), 32'h0000_0305);
    bus(1'b1, 1'b0, ca(9, 2), 32'h0000_0005);
    u_model.set_dma(5, 1'b1);
    idle(4);
    check("inverted burst end", usb_burst_end[0], 1'b1);
    check("acknowledge", pl_ack, 2'b01);
    rd(ca(9, 0));
    check("control 9", got, 32'h0000_0100);
    rd(ca(12, 0));
    check("control 12", got, 32'h0000_0005);
    bus(1'b1, 1'b0, ca(9, 0), 32'h0000_0000);
    u_model.set_dma(5, 1'b0);
  endtask : t_manip
  task automatic t_edge();
    int hits;
    hits = 0;
    bus(1'b1, 1'b0, ca(3, 0), 32'h0000_0200);
    idle(4);
    u_model.set_dma(0, 1'b1);
    repeat (40) begin
      idle(1);
      hits += (dest_trig[12] === 1'b1);
    end
    check("edge pulse", (hits >= 7 && hits <= 11), 1);
    u_model.set_dma(0, 1'b0);
  endtask : t_edge
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_sw_out(0, 2);
    t_sw_out(9, 0);
    t_sw_out(9, 2);
    t_sw_out(8, 3);
    t_sw_in();
    t_sw_dist();
    t_route();
    t_manip();
    t_edge();
    give_verdict();
  end
endmodule : tb
